// *** rtl/umlsc_ctrl.sv ***
// Purpose: one channel's modem control, line/modem status, scratch and baud divisor
// Assumes: receiver, fifos and transmitter on the same clock; modem pins asynchronous
// Notes: registers reached over a plain strobe port, read data one cycle later
module umlsc_ctrl #(
   parameter int unsigned SYNC_STAGES = 2
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // register port
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // receive path
   input wire logic [7:0] receive_holding,
   input wire logic rx_char_done,
   input wire logic rx_char_brk,
   input wire logic rx_is_flow_char,
   input wire logic rx_fifo_full,
   input wire logic rx_fifo_nonempty,
   input wire logic [2:0] rx_head_tags,
   input wire logic rx_fifo_err_any,
   output logic rx_push,
   output logic rx_pop,
   // transmit path
   input wire logic transmit_holding_empty,
   input wire logic transmit_shifter_empty,
   input wire logic tx_serial,
   output logic tx_load,
   output logic tx_resume,
   output logic tx_stop,
   output logic uart_tx_out,
   output logic ir_tx_out,
   output logic ir_enable,
   // modem pins
   input wire logic rx_pin,
   input wire logic cts_in_n,
   input wire logic dsr_in_n,
   input wire logic ring_in_n,
   input wire logic carrier_in_n,
   input wire logic irq_mode_select_pin,
   output logic loopback,
   output logic loop_aux_out_two,
   // interrupt pin
   output logic irq_out,
   output logic irq_out_oe_n,
   // baud
   output logic sample_tick,
   output logic baud_tick
);
   if (SYNC_STAGES < 2) begin : g_bad_sync
      $error("SYNC_STAGES must be at least 2");
   end
   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   logic [5:0] sync_q [SYNC_STAGES];
   logic [5:0] pins;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < SYNC_STAGES; i++) begin
            sync_q[i] <= 6'h3f;
         end
      end else begin
         sync_q[0] <= {irq_mode_select_pin, rx_pin, carrier_in_n, ring_in_n, dsr_in_n, cts_in_n};
         for (int i = 1; i < SYNC_STAGES; i++) begin
            sync_q[i] <= sync_q[i-1];
         end
      end
   end
   assign pins = sync_q[SYNC_STAGES-1];

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   logic [7:0] mcr_q, ier_q, efr_q, lcr_q, spr_q, dll_q, dlm_q;
   logic dlab, wr_mcr;
   assign dlab = lcr_q[umlsc_pkg::LCR_DLAB];
   assign wr_mcr = reg_write && reg_addr == umlsc_pkg::ADDR_MCR;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         mcr_q <= umlsc_pkg::RST_ZERO;
      end else if (wr_mcr) begin
         mcr_q[4:0] <= reg_wdata[4:0];
         if (efr_q[umlsc_pkg::EFR_ENH]) begin
            mcr_q[7:5] <= reg_wdata[7:5];
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ier_q <= umlsc_pkg::RST_ZERO;
         efr_q <= umlsc_pkg::RST_ZERO;
         lcr_q <= umlsc_pkg::RST_ZERO;
         spr_q <= umlsc_pkg::RST_SPR;
         dll_q <= umlsc_pkg::RST_DIV;
         dlm_q <= umlsc_pkg::RST_ZERO;
      end else if (reg_write) begin
         unique case (reg_addr)
            umlsc_pkg::ADDR_DATA_DLL: if (dlab) dll_q <= reg_wdata;
            umlsc_pkg::ADDR_IER_DLM: begin
               if (dlab) begin
                  dlm_q <= reg_wdata;
               end else begin
                  ier_q[3:0] <= reg_wdata[3:0];
                  if (efr_q[umlsc_pkg::EFR_ENH]) ier_q[7:4] <= reg_wdata[7:4];
               end
            end
            umlsc_pkg::ADDR_EFR: efr_q <= reg_wdata;
            umlsc_pkg::ADDR_LCR: lcr_q <= reg_wdata;
            umlsc_pkg::ADDR_SPR: spr_q <= reg_wdata;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // mode outputs
   // ----------------------------------------------------------------
   logic loop_on, ir_on;
   assign loop_on = mcr_q[umlsc_pkg::MCR_LOOP];
   assign ir_on = mcr_q[umlsc_pkg::MCR_IR];
   assign loopback = loop_on;
   assign ir_enable = ir_on;
   // internal aux level is the inverse of the enable bit
   assign loop_aux_out_two = loop_on ? ~mcr_q[umlsc_pkg::MCR_OUT_EN] : 1'b1;
   assign tx_load = reg_write && reg_addr == umlsc_pkg::ADDR_DATA_DLL && !dlab;
   assign rx_pop = reg_read && reg_addr == umlsc_pkg::ADDR_DATA_DLL && !dlab;
   // stop after the current character while remote holds cts high
   assign tx_stop = efr_q[umlsc_pkg::EFR_ACTS] && pins[0] && !loop_on;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         uart_tx_out <= 1'b1;
         ir_tx_out <= 1'b0;
      end else begin
         // idle mark gives a low infrared output
         uart_tx_out <= (ir_on || loop_on) ? 1'b1 : tx_serial;
         ir_tx_out <= ir_on && !loop_on && !tx_serial;
      end
   end

   // ----------------------------------------------------------------
   // receive status
   // ----------------------------------------------------------------
   logic overrun_q, tag_hide_q, break_lock_q, sw_flow_on;
   logic rd_lsr, rd_msr;
   assign rd_lsr = reg_read && reg_addr == umlsc_pkg::ADDR_LSR;
   assign rd_msr = reg_read && reg_addr == umlsc_pkg::ADDR_MSR;
   assign sw_flow_on = efr_q[1:0] != 2'h0;
   assign rx_push = rx_char_done && !rx_fifo_full
      && !(rx_is_flow_char && sw_flow_on)
      && !(rx_char_brk && break_lock_q);
   assign tx_resume = rx_char_done && mcr_q[umlsc_pkg::MCR_ANY];

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         overrun_q <= 1'b0;
      end else if (rx_char_done && rx_fifo_full) begin
         overrun_q <= 1'b1;
      end else if (rd_lsr) begin
         overrun_q <= 1'b0;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         tag_hide_q <= 1'b0;
      end else if (rx_pop) begin
         tag_hide_q <= 1'b0;
      end else if (rd_lsr) begin
         tag_hide_q <= 1'b1;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         break_lock_q <= 1'b0;
      end else if (rx_push && rx_char_brk) begin
         break_lock_q <= 1'b1;
      end else if (pins[4]) begin
         break_lock_q <= 1'b0;
      end
   end

   logic [2:0] shown_tags;
   logic [7:0] lsr_val;
   assign shown_tags = (rx_fifo_nonempty && !tag_hide_q) ? rx_head_tags : 3'h0;
   assign lsr_val = {rx_fifo_err_any,
      transmit_holding_empty && transmit_shifter_empty,
      transmit_holding_empty,
      shown_tags, overrun_q,
      rx_fifo_nonempty};

   // ----------------------------------------------------------------
   // modem status
   // ----------------------------------------------------------------
   logic [3:0] lvl, lvl_q, delta_q, delta_set;
   // order: carrier, ring, dsr, cts
   assign lvl = loop_on ? {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]}
      : ~pins[3:0];
   assign delta_set = {lvl[3] ^ lvl_q[3],
      lvl_q[2] && !lvl[2],
      lvl[1] ^ lvl_q[1], lvl[0] ^ lvl_q[0]};

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         lvl_q <= 4'h0;
         delta_q <= 4'h0;
      end else begin
         lvl_q <= lvl;
         // a change in the clearing cycle is kept
         delta_q <= (rd_msr ? 4'h0 : delta_q) | delta_set;
      end
   end

   // ----------------------------------------------------------------
   // interrupt pin
   // ----------------------------------------------------------------
   logic line_irq, modem_irq;
   assign line_irq = ier_q[umlsc_pkg::IER_LINE] && (overrun_q || shown_tags != 3'h0);
   assign modem_irq = ier_q[umlsc_pkg::IER_MODEM] && delta_q != 4'h0;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         irq_out <= 1'b0;
         irq_out_oe_n <= 1'b1;
      end else begin
         irq_out <= line_irq || modem_irq;
         // select pin held low in the alternate bus mode
         irq_out_oe_n <= !(pins[5] || mcr_q[umlsc_pkg::MCR_OUT_EN]);
      end
   end

   // ----------------------------------------------------------------
   // baud generator
   // ----------------------------------------------------------------
   logic [1:0] pre_q;
   logic [15:0] div_cnt_q, divisor;
   logic [3:0] os_q;
   logic pre_tick;
   assign divisor = {dlm_q, dll_q};
   assign pre_tick = !mcr_q[umlsc_pkg::MCR_PRESC] || pre_q == umlsc_pkg::PRESC_LAST;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pre_q <= 2'h0;
      end else begin
         pre_q <= pre_q + 2'h1;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         div_cnt_q <= 16'h0;
         sample_tick <= 1'b0;
      end else begin
         sample_tick <= 1'b0;
         if (pre_tick && divisor != 16'h0) begin
            if (div_cnt_q >= divisor - 16'h1) begin
               div_cnt_q <= 16'h0;
               sample_tick <= 1'b1;
            end else begin
               div_cnt_q <= div_cnt_q + 16'h1;
            end
         end
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         os_q <= 4'h0;
         baud_tick <= 1'b0;
      end else begin
         baud_tick <= sample_tick && os_q == umlsc_pkg::OVERSAMPLE_LAST;
         if (sample_tick) os_q <= os_q + 4'h1;
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_read) begin
         unique case (reg_addr)
            umlsc_pkg::ADDR_DATA_DLL: reg_rdata <= dlab ? dll_q : receive_holding;
            umlsc_pkg::ADDR_IER_DLM: reg_rdata <= dlab ? dlm_q : ier_q;
            umlsc_pkg::ADDR_EFR: reg_rdata <= efr_q;
            umlsc_pkg::ADDR_LCR: reg_rdata <= lcr_q;
            umlsc_pkg::ADDR_MCR: reg_rdata <= mcr_q;
            umlsc_pkg::ADDR_LSR: reg_rdata <= lsr_val;
            umlsc_pkg::ADDR_MSR: reg_rdata <= {lvl, delta_q};
            umlsc_pkg::ADDR_SPR: reg_rdata <= spr_q;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_IRQ_TRISTATE: assert property (@(posedge clock) disable iff (reset)
      1 |=> irq_out_oe_n == !($past(pins[5]) || $past(mcr_q[3])))
      else $error("irq enable wrong");
   AST_AUX_INV: assert property (@(posedge clock) disable iff (reset)
      loop_on |-> loop_aux_out_two != mcr_q[3])
      else $error("aux out two not inverted");
   AST_MCR_LOCK: assert property (@(posedge clock) disable iff (reset)
      wr_mcr && !efr_q[4] |=> mcr_q[7:5] == $past(mcr_q[7:5]))
      else $error("locked control bits changed");
   AST_OVERRUN: assert property (@(posedge clock) disable iff (reset)
      rx_char_done && rx_fifo_full |-> !rx_push ##1 overrun_q)
      else $error("overrun not flagged");
   AST_LSR_CLR: assert property (@(posedge clock) disable iff (reset)
      rd_lsr && !(rx_char_done && rx_fifo_full) |=> !overrun_q)
      else $error("overrun not cleared by read");
   AST_RING_EDGE: assert property (@(posedge clock) disable iff (reset)
      !rd_msr && $rose(delta_q[2]) |-> $past(lvl_q[2]) && !$past(lvl[2]))
      else $error("ring delta without falling level");
   AST_SCRATCH: assert property (@(posedge clock) disable iff (reset)
      reg_write && reg_addr == 3'h7 ##1 !reg_write ##1 reg_read && reg_addr == 3'h7
      |=> reg_rdata == $past(reg_wdata, 3))
      else $error("scratch lost value");
   AST_BAUD: assert property (@(posedge clock) disable iff (reset)
      sample_tick && divisor > 16'h1 && !mcr_q[7] |=> !sample_tick)
      else $error("sample ticks too close");
   AST_BREAK_ONE: assert property (@(posedge clock) disable iff (reset)
      break_lock_q && rx_char_done && rx_char_brk |-> !rx_push)
      else $error("second break stored");
   AST_TX_EMPTY: assert property (@(posedge clock) disable iff (reset)
      rd_lsr && !transmit_shifter_empty |=> !reg_rdata[6])
      else $error("tx empty while shifter busy");
   COV_OVERRUN: cover property (@(posedge clock) disable iff (reset)
      rx_char_done && rx_fifo_full ##1 rd_lsr);
   COV_MODEM_IRQ: cover property (@(posedge clock) disable iff (reset) $rose(modem_irq));
   COV_LOOP: cover property (@(posedge clock) disable iff (reset) loop_on && delta_q != 4'h0);
   COV_BAUD: cover property (@(posedge clock) disable iff (reset) baud_tick);
endmodule // umlsc_ctrl

// *** rtl/umlsc_pkg.sv ***
// Purpose: constants for the modem/line status control block
// Assumes: 3-bit register address, 8-bit data
// Notes: address map is local to this block
package umlsc_pkg;
   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [2:0] ADDR_DATA_DLL = 3'h0;
   localparam logic [2:0] ADDR_IER_DLM = 3'h1;
   localparam logic [2:0] ADDR_EFR = 3'h2;
   localparam logic [2:0] ADDR_LCR = 3'h3;
   localparam logic [2:0] ADDR_MCR = 3'h4;
   localparam logic [2:0] ADDR_LSR = 3'h5;
   localparam logic [2:0] ADDR_MSR = 3'h6;
   localparam logic [2:0] ADDR_SPR = 3'h7;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int MCR_OUT_EN = 3;
   localparam int MCR_LOOP = 4;
   localparam int MCR_ANY = 5;
   localparam int MCR_IR = 6;
   localparam int MCR_PRESC = 7;
   localparam int IER_LINE = 2;
   localparam int IER_MODEM = 3;
   localparam int EFR_ENH = 4;
   localparam int EFR_ACTS = 7;
   localparam int LCR_DLAB = 7;
   // ----------------------------------------------------------------
   // reset values and counts
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_SPR = 8'hff;
   localparam logic [7:0] RST_DIV = 8'h01;
   localparam logic [1:0] PRESC_LAST = 2'h3;
   localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
endpackage : umlsc_pkg

// *** sim/umlsc_modem_model.sv ***
// Purpose: behavioural remote modem driving the modem pins
// Assumes: modem pins idle high, select pin low; levels requested by the bench
// Notes: slow mode delays each modem pin change by two cycles; the select pin is not delayed
module umlsc_modem_model (
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // requests from the bench
   input wire logic [4:0] want_n,
   input wire logic sel_want,
   input wire logic alt_bus_mode,
   input wire logic slow,
   // modem pins
   output logic rx_pin,
   output logic cts_in_n,
   output logic dsr_in_n,
   output logic ring_in_n,
   output logic carrier_in_n,
   output logic irq_mode_select_pin
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [4:0] pins_q;
   logic [1:0] wait_q;
   logic sel_q;
   // pin order rx, cts, dsr, ring, carrier
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         pins_q <= 5'h1f;
         wait_q <= 2'h0;
      end else if (pins_q != want_n && (!slow || wait_q == 2'h2)) begin
         pins_q <= want_n;
         wait_q <= 2'h0;
      end else begin
         wait_q <= (pins_q != want_n) ? wait_q + 2'h1 : 2'h0;
      end
   end
   // alternate bus mode holds the select pin low
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sel_q <= 1'b0;
      end else begin
         sel_q <= sel_want && !alt_bus_mode;
      end
   end
   assign {rx_pin, cts_in_n, dsr_in_n, ring_in_n, carrier_in_n} = pins_q;
   assign irq_mode_select_pin = sel_q;
endmodule // umlsc_modem_model

// *** sim/tb_uart_modem_line_status_ctrl.sv ***
// Purpose: self-checking bench for the modem/line status control block
// Assumes: register port one-cycle strobes, read data one cycle later
// Notes: register cases from a row table, the rest hand-written
module tb_uart_modem_line_status_ctrl;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [2:0] A_IER = umlsc_pkg::ADDR_IER_DLM;
   localparam logic [2:0] A_EFR = umlsc_pkg::ADDR_EFR;
   localparam logic [2:0] A_LCR = umlsc_pkg::ADDR_LCR;
   localparam logic [2:0] A_MCR = umlsc_pkg::ADDR_MCR;
   localparam logic [2:0] A_LSR = umlsc_pkg::ADDR_LSR;
   localparam logic [2:0] A_MSR = umlsc_pkg::ADDR_MSR;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [7:0] receive_holding = 8'hc3;
   logic rx_char_done = 1'b0;
   logic rx_char_brk = 1'b0;
   logic rx_is_flow_char = 1'b0;
   logic rx_fifo_full = 1'b0;
   logic rx_fifo_nonempty = 1'b0;
   logic [2:0] rx_head_tags = 3'h0;
   logic rx_fifo_err_any = 1'b0;
   logic transmit_holding_empty = 1'b1;
   logic transmit_shifter_empty = 1'b1;
   logic tx_serial = 1'b1;
   logic [4:0] want_n = 5'h1f;
   logic sel_want = 1'b0;
   logic slow = 1'b0;
   logic [7:0] reg_rdata;
   logic rx_push, rx_pop, tx_load, tx_resume, tx_stop, uart_tx_out, ir_tx_out, ir_enable;
   logic rx_pin, cts_in_n, dsr_in_n, ring_in_n, carrier_in_n, irq_mode_select_pin;
   logic loopback, loop_aux_out_two, irq_out, irq_out_oe_n, sample_tick, baud_tick;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;
   // write addr, write data, read addr, expected read
   logic [21:0] rows [10] = '{
      {3'h7, 8'h5a, 3'h7, 8'h5a},
      {A_LCR, 8'h80, 3'h0, 8'h01},
      {3'h0, 8'h34, 3'h0, 8'h34},
      {A_IER, 8'h12, A_IER, 8'h12},
      {A_LCR, 8'h00, A_IER, 8'h00},
      {A_MCR, 8'he8, A_MCR, 8'h08},
      {A_EFR, 8'h10, A_MCR, 8'h08},
      {A_MCR, 8'he8, A_MCR, 8'he8},
      {A_EFR, 8'h00, A_MCR, 8'he8},
      {A_MCR, 8'h08, A_MCR, 8'he8}};
   logic [21:0] row;
   umlsc_ctrl umlsc_ctrl_inst (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
      .reg_rdata, .receive_holding, .rx_char_done, .rx_char_brk, .rx_is_flow_char,
      .rx_fifo_full, .rx_fifo_nonempty, .rx_head_tags, .rx_fifo_err_any, .rx_push, .rx_pop,
      .transmit_holding_empty, .transmit_shifter_empty, .tx_serial, .tx_load, .tx_resume,
      .tx_stop, .uart_tx_out, .ir_tx_out, .ir_enable, .rx_pin, .cts_in_n, .dsr_in_n,
      .ring_in_n, .carrier_in_n, .irq_mode_select_pin, .loopback, .loop_aux_out_two,
      .irq_out, .irq_out_oe_n, .sample_tick, .baud_tick);
   umlsc_modem_model umlsc_modem_model_inst (.clock, .reset, .want_n, .sel_want,
      .alt_bus_mode(1'b0), .slow, .rx_pin, .cts_in_n, .dsr_in_n, .ring_in_n, .carrier_in_n,
      .irq_mode_select_pin);
   always #12.5 clock = ~clock;
   // ----------------------------------------------------------------
   // checking and bus tasks
   // ----------------------------------------------------------------
   task automatic finish_test;
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clock);
      reg_write <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rdc(input logic [2:0] a, input logic [7:0] exp, input string name);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clock);
      reg_read <= 1'b0;
      #1;
      chk(name, {8'h00, exp}, {8'h00, reg_rdata});
      @(posedge clock);
   endtask
   task automatic gap(input int exp, input string name);
      int n;
      int k;
      for (k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge clock);
            #1;
            n++;
         end while (baud_tick !== 1'b1 && n < 600);
      end
      chk(name, exp[15:0], n[15:0]);
      @(posedge clock);
   endtask
   task automatic pulse(input logic flow, input logic push, input logic res);
      rx_is_flow_char <= flow;
      rx_char_done <= 1'b1;
      #1;
      chk("rx push", {15'h0, push}, {15'h0, rx_push});
      chk("tx resume", {15'h0, res}, {15'h0, tx_resume});
      @(posedge clock);
      rx_char_done <= 1'b0;
      @(posedge clock);
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         finish_test;
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      rdc(3'h7, 8'hff, "scratch reset");
      rdc(A_MCR, 8'h00, "control reset");
      chk("oe_n reset", 16'h1, {15'h0, irq_out_oe_n});
      foreach (rows[i]) begin
         row = rows[i];
         wr(row[21:19], row[18:11]);
         rdc(row[10:8], row[7:0], "row read");
      end
      // control e8: prescale, infrared, resume-any, output enable
      chk("oe_n enabled", 16'h0, {15'h0, irq_out_oe_n});
      chk("ir idle", 16'h0, {15'h0, ir_tx_out});
      chk("ir enable", 16'h1, {15'h0, ir_enable});
      tx_serial <= 1'b0;
      repeat (2) @(posedge clock);
      chk("ir pulse", 16'h1, {15'h0, ir_tx_out});
      chk("uart tx in ir", 16'h1, {15'h0, uart_tx_out});
      pulse(1'b0, 1'b1, 1'b1);
      wr(A_EFR, 8'h10);
      wr(A_MCR, 8'h08);
      pulse(1'b0, 1'b1, 1'b0);
      wr(A_LCR, 8'h80);
      wr(3'h0, 8'h02);
      wr(A_IER, 8'h00);
      wr(A_LCR, 8'h00);
      gap(16 * 2, "baud period");
      wr(A_MCR, 8'h88);
      gap(16 * 2 * 4, "prescaled period");
      wr(A_MCR, 8'h00);
      @(posedge clock);
      chk("oe_n tristate", 16'h1, {15'h0, irq_out_oe_n});
      sel_want <= 1'b1;
      repeat (6) @(posedge clock);
      chk("oe_n select", 16'h0, {15'h0, irq_out_oe_n});
      sel_want <= 1'b0;
      wr(A_MCR, 8'h1b);
      chk("loopback", 16'h1, {15'h0, loopback});
      chk("aux two", 16'h0, {15'h0, loop_aux_out_two});
      @(posedge clock);
      chk("uart tx loop", 16'h1, {15'h0, uart_tx_out});
      rdc(A_MSR, 8'hbb, "loop status");
      wr(A_MCR, 8'h10);
      chk("aux two off", 16'h1, {15'h0, loop_aux_out_two});
      wr(A_MCR, 8'h00);
      rdc(A_MSR, 8'h0b, "normal status");
      wr(A_IER, 8'h08);
      want_n <= 5'h17;
      repeat (6) @(posedge clock);
      chk("modem irq", 16'h1, {15'h0, irq_out});
      rdc(A_MSR, 8'h11, "cts delta");
      rdc(A_MSR, 8'h10, "delta cleared");
      chk("modem irq off", 16'h0, {15'h0, irq_out});
      slow <= 1'b1;
      want_n <= 5'h15;
      repeat (10) @(posedge clock);
      rdc(A_MSR, 8'h50, "ring start");
      want_n <= 5'h17;
      repeat (10) @(posedge clock);
      rdc(A_MSR, 8'h14, "ring end");
      slow <= 1'b0;
      wr(A_EFR, 8'h90);
      chk("cts go", 16'h0, {15'h0, tx_stop});
      want_n <= 5'h1f;
      repeat (6) @(posedge clock);
      chk("cts stop", 16'h1, {15'h0, tx_stop});
      wr(A_IER, 8'h04);
      rx_fifo_nonempty <= 1'b1;
      rx_head_tags <= 3'h2;
      rx_fifo_err_any <= 1'b1;
      rdc(A_LSR, 8'he9, "line status");
      rdc(3'h0, 8'hc3, "data read");
      rx_fifo_full <= 1'b1;
      pulse(1'b0, 1'b0, 1'b0);
      chk("line irq", 16'h1, {15'h0, irq_out});
      rdc(A_LSR, 8'heb, "overrun");
      rdc(A_LSR, 8'he1, "read cleared");
      @(posedge clock);
      chk("line irq off", 16'h0, {15'h0, irq_out});
      rx_fifo_full <= 1'b0;
      wr(A_EFR, 8'h11);
      pulse(1'b1, 1'b0, 1'b0);
      rx_fifo_nonempty <= 1'b0;
      transmit_shifter_empty <= 1'b0;
      rdc(A_LSR, 8'ha0, "empty fifo");
      transmit_holding_empty <= 1'b0;
      rdc(A_LSR, 8'h80, "holding full");
      // break held low: one break stored until the line returns to mark
      want_n <= 5'h0f;
      rx_char_brk <= 1'b1;
      repeat (6) @(posedge clock);
      pulse(1'b0, 1'b1, 1'b0);
      pulse(1'b0, 1'b0, 1'b0);
      want_n <= 5'h1f;
      repeat (6) @(posedge clock);
      pulse(1'b0, 1'b1, 1'b0);
      rx_char_brk <= 1'b0;
      finish_test;
   end
endmodule // tb_uart_modem_line_status_ctrl
